/* rtl/ssr_pkg.sv */
// package for the state sensor readings responder
package ssr_pkg;
  // handle values that never name a sensor, result codes, count limits and reset state values
  localparam logic [15:0] HANDLE_RSVD_LO = 16'h0000;
  localparam logic [15:0] HANDLE_RSVD_HI = 16'hFFFF;
  localparam logic [7:0]  RC_SUCCESS     = 8'h00;
  localparam logic [7:0]  RC_BAD_HANDLE  = 8'h80;
  localparam logic [3:0]  CNT_MIN        = 4'h1;
  localparam logic [3:0]  CNT_MAX        = 4'h8;
  localparam logic [7:0]  STATE_UNKNOWN  = 8'h00;
  localparam logic [7:0]  OPSTATE_RESET  = 8'h00;
  // request byte positions
  localparam logic [1:0]  REQ_HANDLE_LO  = 2'h0;
  localparam logic [1:0]  REQ_HANDLE_HI  = 2'h1;
  localparam logic [1:0]  REQ_REARM      = 2'h2;
  localparam logic [1:0]  REQ_RSVD       = 2'h3;
  // register offsets
  localparam logic [3:0]  A_STATUS       = 4'h0;
  localparam logic [3:0]  A_CLEAR        = 4'h1;
  localparam logic [3:0]  A_ENABLE       = 4'h2;
  localparam logic [3:0]  A_LHAND        = 4'h3;
  localparam logic [3:0]  A_HHAND        = 4'h4;
  // interrupt status bit positions and width
  localparam int          IRQ_DONE_BIT   = 0;
  localparam int          IRQ_BAD_BIT    = 1;
  localparam int          IRQ_W          = 2;

  typedef enum logic [2:0] {
    SSR_IDLE  = 3'b000,
    SSR_CODE  = 3'b001,
    SSR_COUNT = 3'b011,
    SSR_REC   = 3'b010,
    SSR_DONE  = 3'b110
  } ssr_state_t;
endpackage

/* rtl/ssr_responder.sv */
// read-state-sensors command responder
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// [R1] handle 0 and all-ones never valid
// [R2] rearm bit n selects sub-sensor n
// [R3] set bit re-arms, clear leaves arming
// [R4] re-arm only below sub-sensor count
// [R5] response opens with result code
// [R6] count byte one to eight follows
// [R7] one record per sub-sensor, offset order
// [R8] record count fixed regardless of status
// [R9] record: operating, current, prior, event
// [R10] prior updates when current state changes
// [R11] unknown prior reports equal to current
// [R12] reserved request byte carries no meaning
module ssr_responder #(
  parameter logic [15:0] MY_HANDLE = 16'h0001,
  parameter logic [3:0]  SUB_COUNT = 4'h8
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // request byte stream
  input  wire logic        req_valid,
  input  wire logic [7:0]  req_byte,
  input  wire logic        req_last,
  // response byte stream
  output logic             rsp_valid,
  output logic [7:0]       rsp_byte,
  output logic             rsp_last,
  // sensing side, one assessment per sub-sensor
  input  wire logic [7:0]  assess_valid,
  input  wire logic [63:0] assess_state,
  input  wire logic [7:0]  event_valid,
  input  wire logic [63:0] opstate_in,
  input  wire logic [7:0]  init_pulse,
  output logic [7:0]       rearm_pulse,
  output logic [7:0]       armed,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  output logic             irq
);
  ssr_pkg::ssr_state_t st_q, st_d;
  logic [1:0]  rx_idx_q;
  logic [15:0] handle_q;
  logic [7:0]  rearm_q;
  logic        req_done;
  logic [2:0]  rec_q;
  logic [1:0]  fld_q;
  logic [7:0]  cur_q   [8];
  logic [7:0]  prior_q [8];
  logic [7:0]  evt_q   [8];
  logic [7:0]  known_q;
  logic [7:0]  armed_q;
  localparam int IRQ_W_L = ssr_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] sts_q, en_q;

  // [R12] reserved byte taken and ignored
  assign req_done = req_valid && req_last;

  // [R1] reserved handles never match
  wire handle_ok = (handle_q != ssr_pkg::HANDLE_RSVD_LO) &&
                   (handle_q != ssr_pkg::HANDLE_RSVD_HI) &&
                   (handle_q == MY_HANDLE);
  wire [3:0] cnt_eff = (SUB_COUNT > ssr_pkg::CNT_MAX) ? ssr_pkg::CNT_MAX :
                       (SUB_COUNT < ssr_pkg::CNT_MIN) ? ssr_pkg::CNT_MIN : SUB_COUNT;
  wire last_rec = ({1'b0, rec_q} == cnt_eff - 4'h1);

  // request capture
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_idx_q <= 2'h0;
      handle_q <= 16'h0000;
      rearm_q  <= 8'h00;
    end else if (req_valid && st_q == ssr_pkg::SSR_IDLE) begin
      rx_idx_q <= req_last ? 2'h0 : rx_idx_q + 2'h1;
      case (rx_idx_q)
        ssr_pkg::REQ_HANDLE_LO: handle_q[7:0]  <= req_byte;
        ssr_pkg::REQ_HANDLE_HI: handle_q[15:8] <= req_byte;
        ssr_pkg::REQ_REARM:     rearm_q        <= req_byte;
        default: ;
      endcase
    end
  end

  // response sequencer
  always_comb begin
    st_d = st_q;
    case (st_q)
      ssr_pkg::SSR_IDLE:  if (req_done) st_d = ssr_pkg::SSR_CODE;
      ssr_pkg::SSR_CODE:  st_d = handle_ok ? ssr_pkg::SSR_COUNT : ssr_pkg::SSR_DONE;
      ssr_pkg::SSR_COUNT: st_d = ssr_pkg::SSR_REC;
      ssr_pkg::SSR_REC:   if (last_rec && fld_q == 2'h3) st_d = ssr_pkg::SSR_DONE;
      ssr_pkg::SSR_DONE:  st_d = ssr_pkg::SSR_IDLE;
      default:            st_d = ssr_pkg::SSR_IDLE;
    endcase
  end

  // [R9] record field order
  wire [7:0] op_b   = opstate_in[8*rec_q +: 8];
  wire [7:0] fld_b  = (fld_q == 2'h0) ? op_b :
                      (fld_q == 2'h1) ? cur_q[rec_q] :
                      (fld_q == 2'h2) ? prior_q[rec_q] : evt_q[rec_q];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_q      <= ssr_pkg::SSR_IDLE;
      rec_q     <= 3'h0;
      fld_q     <= 2'h0;
      rsp_valid <= 1'b0;
      rsp_byte  <= 8'h00;
      rsp_last  <= 1'b0;
    end else begin
      st_q      <= st_d;
      rsp_valid <= 1'b0;
      rsp_last  <= 1'b0;
      case (st_q)
        // [R5] result code first
        ssr_pkg::SSR_CODE: begin
          rsp_valid <= 1'b1;
          rsp_byte  <= handle_ok ? ssr_pkg::RC_SUCCESS : ssr_pkg::RC_BAD_HANDLE;
          rsp_last  <= !handle_ok;
          rec_q     <= 3'h0;
          fld_q     <= 2'h0;
        end
        // [R6] count byte
        ssr_pkg::SSR_COUNT: begin
          rsp_valid <= 1'b1;
          rsp_byte  <= {4'h0, cnt_eff};
        end
        // [R7] [R8] fixed count, offset order
        ssr_pkg::SSR_REC: begin
          rsp_valid <= 1'b1;
          rsp_byte  <= fld_b;
          rsp_last  <= last_rec && fld_q == 2'h3;
          fld_q     <= fld_q + 2'h1;
          if (fld_q == 2'h3) rec_q <= rec_q + 3'h1;
        end
        default: ;
      endcase
    end
  end

  // per-sub-sensor state tracking
  genvar n;
  generate
    for (n = 0; n < 8; n++) begin : g_sub
      wire [7:0] new_s = assess_state[8*n +: 8];
      // [R2] [R3] [R4] re-arm bit n only below count
      wire rearm_n = (st_q == ssr_pkg::SSR_CODE) && handle_ok &&
                     rearm_q[n] && (n < cnt_eff);
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          cur_q[n]       <= ssr_pkg::STATE_UNKNOWN;
          prior_q[n]     <= ssr_pkg::STATE_UNKNOWN;
          evt_q[n]       <= ssr_pkg::STATE_UNKNOWN;
          known_q[n]     <= 1'b0;
          armed_q[n]     <= 1'b1;
          rearm_pulse[n] <= 1'b0;
        end else begin
          rearm_pulse[n] <= rearm_n;
          if (init_pulse[n]) begin
            known_q[n] <= 1'b0;
          end else if (assess_valid[n]) begin
            known_q[n] <= 1'b1;
            cur_q[n]   <= new_s;
            // [R11] unknown prior mirrors current
            if (!known_q[n]) prior_q[n] <= new_s;
            // [R10] prior takes old current on change
            else if (new_s != cur_q[n]) prior_q[n] <= cur_q[n];
            if (event_valid[n]) evt_q[n] <= new_s;
          end
          // event disarms until re-armed; event wins over re-arm
          if (assess_valid[n] && event_valid[n]) armed_q[n] <= 1'b0;
          else if (rearm_n) armed_q[n] <= 1'b1;
        end
      end
    end
  endgenerate
  assign armed = armed_q;

  // interrupts: done and bad-handle events
  wire [IRQ_W_L-1:0] ev;
  assign ev[ssr_pkg::IRQ_DONE_BIT] = (st_q == ssr_pkg::SSR_DONE);
  assign ev[ssr_pkg::IRQ_BAD_BIT]  = (st_q == ssr_pkg::SSR_CODE) && !handle_ok;
  wire wr_clr = reg_wr && reg_addr == ssr_pkg::A_CLEAR;
  wire [IRQ_W_L-1:0] clr = wr_clr ? reg_wdata[IRQ_W_L-1:0] : '0;
  wire [7:0] rd_mux = (reg_addr == ssr_pkg::A_STATUS) ? {6'h00, sts_q} :
                      (reg_addr == ssr_pkg::A_ENABLE) ? {6'h00, en_q} :
                      (reg_addr == ssr_pkg::A_LHAND)  ? MY_HANDLE[7:0] :
                      (reg_addr == ssr_pkg::A_HHAND)  ? MY_HANDLE[15:8] : 8'h00;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sts_q     <= '0;
      en_q      <= '0;
      reg_rdata <= 8'h00;
      irq       <= 1'b0;
    end else begin
      sts_q     <= (sts_q & ~clr) | ev;
      if (reg_wr && reg_addr == ssr_pkg::A_ENABLE) en_q <= reg_wdata[IRQ_W_L-1:0];
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
      irq       <= |(((sts_q & ~clr) | ev) & en_q);
    end
  end

  // byte count of the response in flight; helper for the length check only
  logic [5:0] rsp_n_q;
  // last byte follows code, count and four bytes per record, less the last byte itself
  wire  [5:0] rsp_len_exp = {cnt_eff, 2'h0} + 6'h01;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rsp_n_q <= 6'h00;
    end else if (st_q == ssr_pkg::SSR_CODE) begin
      rsp_n_q <= 6'h00;
    end else if (rsp_valid) begin
      rsp_n_q <= rsp_n_q + 6'h01;
    end
  end

  // [R5] bad handle specific code
  a_bad_code: assert property (@(posedge sys_clk) disable iff (!resetn) // [R5]
    (st_q == ssr_pkg::SSR_CODE && !handle_ok) |=> rsp_valid && rsp_byte == ssr_pkg::RC_BAD_HANDLE && rsp_last)
    else $error("bad handle not answered with 0x80");
  // [R6] count in range
  a_count_range: assert property (@(posedge sys_clk) disable iff (!resetn) // [R6]
    (st_q == ssr_pkg::SSR_COUNT) |=> rsp_byte >= 8'h01 && rsp_byte <= 8'h08)
    else $error("count byte out of range");
  // [R1] reserved handles refused
  a_rsvd_handle: assert property (@(posedge sys_clk) disable iff (!resetn) // [R1]
    (handle_q == 16'hFFFF || handle_q == 16'h0000) |-> !handle_ok)
    else $error("reserved handle accepted");
  // [R10] prior on change
  a_prior_upd: assert property (@(posedge sys_clk) disable iff (!resetn) // [R10]
    (assess_valid[0] && !init_pulse[0] && known_q[0] && assess_state[7:0] != cur_q[0])
      |=> prior_q[0] == $past(cur_q[0]))
    else $error("prior state not updated");
  // [R11] unknown prior mirrors
  a_prior_unk: assert property (@(posedge sys_clk) disable iff (!resetn) // [R11]
    (assess_valid[0] && !init_pulse[0] && !known_q[0]) |=> prior_q[0] == cur_q[0])
    else $error("unknown prior not equal to current");
  // [R3] set bit re-arms
  a_rearm_hit: assert property (@(posedge sys_clk) disable iff (!resetn) // [R3]
    (st_q == ssr_pkg::SSR_CODE && handle_ok && rearm_q[0]) |=> rearm_pulse[0])
    else $error("re-arm bit ignored");
  // [R4] no re-arm above count
  a_rearm_lim: assert property (@(posedge sys_clk) disable iff (!resetn) // [R4]
    (cnt_eff < 4'h8) |=> !rearm_pulse[7])
    else $error("re-arm beyond count");
  // [R8] one record length
  a_rec_len: assert property (@(posedge sys_clk) disable iff (!resetn) // [R8]
    (st_q == ssr_pkg::SSR_COUNT && cnt_eff == 4'h1) |=> (rsp_valid && !rsp_last) [*4] ##1 rsp_last)
    else $error("record length wrong");
  // [R8] two records length
  a_rec_len2: assert property (@(posedge sys_clk) disable iff (!resetn) // [R8]
    (st_q == ssr_pkg::SSR_COUNT && cnt_eff == 4'h2) |=> (rsp_valid && !rsp_last) [*8] ##1 (rsp_valid && rsp_last))
    else $error("two-record length wrong");
  // [R7] total response length
  a_rsp_total: assert property (@(posedge sys_clk) disable iff (!resetn) // [R7]
    (rsp_valid && rsp_last && rsp_n_q != 6'h00) |-> rsp_n_q == rsp_len_exp)
    else $error("response length does not match count");
  // [R3] clear bit leaves arming
  a_rearm_none: assert property (@(posedge sys_clk) disable iff (!resetn) // [R3]
    (st_q == ssr_pkg::SSR_CODE && !rearm_q[1]) |=> !rearm_pulse[1])
    else $error("re-arm without mask bit");
  // [R1] bad handle no re-arm
  a_rearm_bad: assert property (@(posedge sys_clk) disable iff (!resetn) // [R1]
    (st_q == ssr_pkg::SSR_CODE && !handle_ok) |=> rearm_pulse == 8'h00)
    else $error("re-arm on bad handle");
  // [R3] event disarms sensor
  a_evt_disarm: assert property (@(posedge sys_clk) disable iff (!resetn) // [R3]
    (assess_valid[0] && event_valid[0]) |=> !armed[0])
    else $error("event did not disarm");
  // [R9] event state captured
  a_evt_state: assert property (@(posedge sys_clk) disable iff (!resetn) // [R9]
    (assess_valid[0] && event_valid[0] && !init_pulse[0]) |=> evt_q[0] == $past(assess_state[7:0]))
    else $error("event state not captured");
  // [R5] code byte first
  a_code_first: assert property (@(posedge sys_clk) disable iff (!resetn) // [R5]
    (st_q == ssr_pkg::SSR_CODE) |=> rsp_valid && (rsp_byte == ssr_pkg::RC_SUCCESS || rsp_byte == ssr_pkg::RC_BAD_HANDLE))
    else $error("response does not open with a code");
  // [R8] records back to back
  a_rsp_b2b: assert property (@(posedge sys_clk) disable iff (!resetn) // [R8]
    (st_q == ssr_pkg::SSR_REC) |=> rsp_valid)
    else $error("gap inside the records");
  // response ends cleanly
  a_last_once: assert property (@(posedge sys_clk) disable iff (!resetn)
    (rsp_valid && rsp_last) |=> !rsp_valid)
    else $error("byte after the last one");
  // interrupt level follows status
  a_irq_level: assert property (@(posedge sys_clk) disable iff (!resetn)
    (en_q == $past(en_q)) |-> irq == |(sts_q & en_q))
    else $error("interrupt level wrong");
  // status sticky, set wins
  a_sts_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
    (ev != '0) |=> (sts_q & $past(ev)) == $past(ev))
    else $error("status event lost");
  // read data idle at zero
  a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without a read");
endmodule

/* bench/ssr_requester.sv */
// requester model driving requests and collecting responses
`timescale 1ns/1ps
module ssr_requester (
  input  wire logic        sys_clk,
  input  wire logic        go,
  input  wire logic [15:0] handle,
  input  wire logic [7:0]  mask,
  output logic             req_valid,
  output logic [7:0]       req_byte,
  output logic             req_last,
  input  wire logic        rsp_valid,
  input  wire logic [7:0]  rsp_byte,
  input  wire logic        rsp_last,
  output logic [7:0]       rx [16],
  output logic [4:0]       rx_n,
  output logic             done
);
  logic [2:0] ph_q = 3'h0;
  logic       tog_q = 1'b0;
  assign req_valid = ph_q != 3'h0;
  assign req_last  = ph_q == 3'h4;
  // handle low byte first, mask, zero reserved byte
  assign req_byte  = ph_q == 3'h1 ? handle[7:0] : ph_q == 3'h2 ? handle[15:8] :
                     ph_q == 3'h3 ? mask : ph_q == 3'h4 ? 8'h00 : {8{tog_q}};
  // idle byte toggles so a stale value never looks valid
  always @(posedge sys_clk) begin
    tog_q <= ~tog_q;
    ph_q  <= go ? 3'h1 : (req_last ? 3'h0 : ph_q + {2'h0, req_valid});
    if (go) begin
      rx_n <= 5'h00;
      done <= 1'b0;
    end else if (rsp_valid) begin
      rx[rx_n[3:0]] <= rsp_byte;
      rx_n          <= rx_n + 5'h01;
      done          <= rsp_last;
    end
  end
endmodule

/* bench/ssr_responder_tb.sv */
// self-checking bench for the sensor readings responder
`timescale 1ns/1ps
module ssr_responder_tb;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        go = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] hnd = 16'h0000;
  logic [7:0]  msk = 8'h00;
  logic [7:0]  av = 8'h00;
  logic [7:0]  ev = 8'h00;
  logic [7:0]  ini = 8'h00;
  logic [7:0]  seen = 8'h00;
  logic [7:0]  wd = 8'h00;
  logic [3:0]  ra = 4'h0;
  logic [63:0] ast = 64'h0;
  logic        req_valid, req_last, rsp_valid, rsp_last, irq, done;
  logic [7:0]  req_byte, rsp_byte, rearm_pulse, armed, reg_rdata;
  logic [7:0]  rx [16];
  logic [4:0]  rx_n;
  int          errors = 0;
  int          checks_done = 0;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) seen <= go ? 8'h00 : seen | rearm_pulse;
  ssr_responder #(.MY_HANDLE(16'h1234), .SUB_COUNT(4'h2)) DUT (.sys_clk, .resetn, .req_valid, .req_byte,
    .req_last, .rsp_valid, .rsp_byte, .rsp_last, .assess_valid(av), .assess_state(ast), .event_valid(ev),
    .opstate_in(64'h0102), .init_pulse(ini), .rearm_pulse, .armed, .reg_addr(ra), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata, .irq);
  ssr_requester host (.sys_clk, .go, .handle(hnd), .mask(msk), .req_valid, .req_byte, .req_last,
    .rsp_valid, .rsp_byte, .rsp_last, .rx, .rx_n, .done);
  task automatic check(input string what, input logic [63:0] seen_v, input logic [63:0] exp_v);
    checks_done++;
    if (seen_v !== exp_v) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp_v, seen_v);
    end
  endtask
  task automatic finish_test;
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic req(input logic [15:0] h, input logic [7:0] m);
    go  <= 1'b1;
    hnd <= h;
    msk <= m;
    @(posedge sys_clk) go <= 1'b0;
    @(negedge sys_clk);
    for (int i = 0; i < 40 && done !== 1'b1; i++) @(negedge sys_clk);
    check("response end", done, 1'b1);
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic resp(input logic [79:0] e);
    check("length", rx_n, 5'h0A);
    for (int i = 0; i < 10; i++) check("record byte", rx[i], e[79-8*i -: 8]);
  endtask
  task automatic sense(input int n, input logic [7:0] st, input logic e);
    av             <= 8'h01 << n;
    ev             <= {7'h00, e} << n;
    ast[n*8 +: 8]  <= st;
    @(posedge sys_clk) av <= 8'h00;
    ev <= 8'h00;
    @(posedge sys_clk);
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    ra <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge sys_clk) wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [7:0] e);
    ra <= a;
    rd <= 1'b1;
    @(posedge sys_clk) rd <= 1'b0;
    @(negedge sys_clk) check("register", reg_rdata, e);
    @(posedge sys_clk);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(negedge sys_clk);
    check("irq", irq, e);
    @(posedge sys_clk);
  endtask
  task automatic t_bad;
    logic [15:0] bad [3] = '{16'h0000, 16'hFFFF, 16'h3412};
    wreg(4'h2, 8'h02);
    foreach (bad[i]) begin
      req(bad[i], 8'hFF);
      check("bad code", rx[0], 8'h80);
      check("bad length", rx_n, 5'h01);
      check("bad rearm", seen, 8'h00);
      irq_is(1'b1);
    end
    rreg(4'h0, 8'h03);
    wreg(4'h1, 8'h02);
    irq_is(1'b0);
  endtask
  task automatic t_states;
    sense(0, 8'h05, 1'b0);
    sense(0, 8'h07, 1'b1);
    sense(0, 8'h07, 1'b0);
    sense(1, 8'h03, 1'b0);
    req(16'h1234, 8'h00);
    check("no rearm", seen, 8'h00);
    check("armed", armed, 8'hFE);
    resp(80'h0002_02070507_01030300);
    req(16'h1234, 8'hFF);
    check("rearm", seen, 8'h03);
    check("rearmed", armed, 8'hFF);
    resp(80'h0002_02070507_01030300);
    ini <= 8'h02;
    @(posedge sys_clk) ini <= 8'h00;
    sense(1, 8'h04, 1'b0);
    req(16'h1234, 8'h00);
    resp(80'h0002_02070507_01040400);
  endtask
  task automatic t_regs;
    rreg(4'h0, 8'h01);
    rreg(4'h1, 8'h00);
    rreg(4'h2, 8'h02);
    rreg(4'hF, 8'h00);
    wreg(4'h2, 8'h01);
    irq_is(1'b1);
    wreg(4'h1, 8'h01);
    irq_is(1'b0);
    rreg(4'h0, 8'h00);
  endtask
  task automatic t_reset;
    sense(0, 8'h09, 1'b1);
    resetn <= 1'b0;
    @(posedge sys_clk) resetn <= 1'b1;
    check("reset armed", armed, 8'hFF);
    check("reset irq", irq, 1'b0);
    rreg(4'h2, 8'h00);
    rreg(4'h0, 8'h00);
    req(16'h1234, 8'h00);
    resp(80'h0002_02000000_01000000);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    t_bad;
    t_states;
    t_regs;
    t_reset;
    finish_test;
  end
  initial begin
    #100000;
    errors++;
    finish_test;
  end
endmodule
